// >>> bench/ecc_unit_asserts.sv
// Port-level checker for the ECC unit datapath and register bus
module ecc_unit_asserts
  import ecc_unit_pkg::*;
#(
  parameter int DATA_W = DEFAULT_DATA_W
) (
  input wire logic                      i_clk,
  input wire logic                      i_nrst,
  input wire logic                      i_wb_cyc,
  input wire logic                      i_wb_stb,
  input wire logic                      o_wb_ack,
  input wire logic                      i_read_write,
  input wire logic [DATA_W/BYTE_W-1:0]  i_byte_output_mask_n,
  input wire logic [DATA_W-1:0]         o_data_out_write_in_bus,
  input wire logic [DATA_W-1:0]         o_data_out_write_in_oe,
  input wire logic [ham_bits(DATA_W):0] o_syndrome_checkbit_out_bus,
  input wire logic                      o_error,
  input wire logic                      o_correctable_error
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PAR_BIT = ham_bits(DATA_W);  // Overall parity place in the syndrome
  logic [DATA_W-1:0] lane_en;                 // Byte masks spread over their pins

  default clocking dcb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // Each mask bit governs the eight pins of its lane
  always_comb begin
    for (int b = 0; b < DATA_W / BYTE_W; b++) begin
      lane_en[b*BYTE_W +: BYTE_W] = {BYTE_W{i_byte_output_mask_n[b]}};
    end
  end

  // Bus request still waiting, read/write turnaround, live read cycle
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_turn;
    i_read_write ##1 !i_read_write;
  endsequence
  sequence s_read;
    i_nrst && i_read_write;
  endsequence

  a_ack_next: assert property (s_req |=> o_wb_ack)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_oe_lanes: assert property (
    i_nrst |=> o_data_out_write_in_oe == $past(lane_en))
    else $error("pin enables differ from byte masks");
  a_flags_write: assert property (
    i_nrst && !i_read_write |=> !o_error && !o_correctable_error)
    else $error("error flags raised in a write cycle");
  a_err_syndrome: assert property (
    s_read |=> o_error == (o_syndrome_checkbit_out_bus != '0))
    else $error("error flag disagrees with syndrome");
  a_double_flag: assert property (
    s_read |=> (!o_syndrome_checkbit_out_bus[PAR_BIT] |-> !o_correctable_error))
    else $error("even-parity error called correctable");
  a_ce_with_err: assert property (o_correctable_error |-> o_error)
    else $error("correctable flag without error flag");
  a_rmw_hold: assert property (
    s_turn ##1 !i_read_write |=> $stable(o_data_out_write_in_bus))
    else $error("held word changed during write-back");
endmodule

// >>> bench/ram_model.sv
// Behavioural DRAM word with check bits and read fault injection
module ram_model (
  input  wire logic        i_clk,
  input  wire logic        i_we,     // Store word and check bits
  input  wire logic        i_rd,     // Array drives its outputs
  input  wire logic [15:0] i_wdata,
  input  wire logic [5:0]  i_wchk,
  input  wire logic [21:0] i_flip,   // Fault pattern {check, data}
  output logic      [15:0] o_data,
  output logic      [5:0]  o_chk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [21:0] mem_reg  = 22'h0;  // Zero word is a valid codeword
  logic [21:0] last_reg = 22'h0;  // Last value put on the outputs

  // Store port; remember what was driven
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_reg <= {i_wchk, i_wdata};
    end
    if (i_rd) begin
      last_reg <= mem_reg ^ i_flip;
    end
  end

  // Released outputs invert so a stale word never looks valid
  assign {o_chk, o_data} = i_rd ? (mem_reg ^ i_flip) : ~last_reg;
endmodule

// >>> bench/tb.sv
// Self-checking bench: register bus, reads with faults, writes, turnaround
module tb
  import ecc_unit_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] WORD = 16'hA5C3;  // Stored test word
  logic        i_clk  = 1'b0;
  logic        i_nrst = 1'b0;
  logic        req    = 1'b0;   // Cyc and stb rise and fall together
  logic        wb_we  = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wd  = 32'h0000_0000;
  logic        rw     = 1'b1;   // High at reset so no turnaround is seen
  logic        correction_enable_n_n = 1'b0;
  logic [1:0]  mask_n = 2'h0;
  logic        strb   = 1'b0;
  logic        we     = 1'b0;
  logic [15:0] din    = 16'h0000; // System side write data
  logic [21:0] flip   = 22'h0;
  logic [15:0] ram_d, dout, oe, pin;
  logic [5:0]  ram_c, cbo;
  logic [31:0] wb_rd, dp;
  logic        ack, irq, err, ce;
  int          fails = 0;
  int          total_checks = 0;

  always #10 i_clk = ~i_clk;
  // Shared pin: our drive where the unit is not driving
  assign pin = (oe & dout) | (~oe & din);
  assign dp  = {8'h00, err, ce, cbo, dout};

  ecc_unit #(.DATA_W(16)) i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(req),
    .i_wb_stb(req), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_wd), .i_wb_sel(4'hF),
    .o_wb_dat(wb_rd), .o_wb_ack(ack), .o_irq(irq), .i_ram_data_in_bus(ram_d),
    .i_stored_check_in_bus(ram_c), .i_input_latch_strobe(strb), .i_read_write(rw),
    .i_correction_enable_n(correction_enable_n_n), .i_byte_output_mask_n(mask_n),
    .i_data_out_write_in_bus(pin), .o_data_out_write_in_bus(dout),
    .o_data_out_write_in_oe(oe), .o_syndrome_checkbit_out_bus(cbo), .o_error(err),
    .o_correctable_error(ce));
  ram_model i_ram (.i_clk(i_clk), .i_we(we), .i_rd(rw), .i_wdata(din), .i_wchk(cbo),
    .i_flip(flip), .o_data(ram_d), .o_chk(ram_c));

  // Reference code: Hamming bits over positions that are no power of two
  function automatic logic [5:0] chk_of(input logic [15:0] d);
    int n;
    logic [4:0] h;
    n = 0;
    h = 5'h00;
    for (int p = 3; n < 16; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int j = 0; j < 5; j++) begin
          if (p[j]) h[j] = h[j] ^ d[n];
        end
        n++;
      end
    end
    return {^d ^ ^h, h};
  endfunction

  // Expected read outputs for the stored word seen through a fault pattern
  function automatic logic [31:0] exp_rd(input logic [21:0] f, input logic [1:0] fl,
                                         input logic [15:0] d);
    logic [21:0] r;
    logic [5:0]  g;
    r = {chk_of(WORD), WORD} ^ f;
    g = chk_of(r[15:0]);
    return {8'h00, fl, ^r, g[4:0] ^ r[20:16], d};
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle; waits for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge i_clk);
    req    <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_wd  <= d;
    do begin
      @(posedge i_clk);
    end while (ack !== 1'b1);
    q = wb_rd;
    req   <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    cmp(q, e);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // One datapath cycle; returns once the registered outputs settle
  task automatic step(input logic r, input logic [21:0] f, input logic c,
                      input logic [1:0] m, input logic s);
    @(posedge i_clk);
    rw     <= r;
    flip   <= f;
    correction_enable_n_n <= c;
    mask_n <= m;
    strb   <= s;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the tests need only about a hundred cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd_reg(CTRL_OFS, CTRL_RST);
    rd_reg(STATUS_OFS, 32'(STATUS_RST));
    rd_reg(MASK_OFS, 32'(MASK_RST));
    rd_reg(8'h40, 32'h0000_0000);
    // Pure write: check bits from pin data, then stored in the array
    din <= WORD;
    step(1'b0, 22'h0, 1'b0, 2'h0, 1'b0);
    cmp(dp & 32'h00FF_0000, {8'h00, 2'b00, chk_of(WORD), 16'h0000});
    we <= 1'b1;
    @(posedge i_clk);
    we <= 1'b0;
    step(1'b1, 22'h0, 1'b0, 2'h3, 1'b0);
    cmp(dp, exp_rd(22'h0, 2'b00, WORD));
    // Every single data or check bit fault is corrected or left out of the data
    for (int i = 0; i < 22; i++) begin
      step(1'b1, 22'h1 << i, 1'b0, 2'h3, 1'b0);
      cmp(dp, exp_rd(22'h1 << i, 2'b11, WORD));
    end
    step(1'b1, 22'h3, 1'b0, 2'h3, 1'b0);
    cmp(dp, exp_rd(22'h3, 2'b10, WORD ^ 16'h0003));
    step(1'b1, 22'h10, 1'b1, 2'h3, 1'b0);
    cmp(dp, exp_rd(22'h10, 2'b11, WORD ^ 16'h0010));
    // Strobe mode keeps the latched word while the array shows garbage
    wr_reg(CTRL_OFS, 32'h0000_0001);
    step(1'b1, 22'h0, 1'b0, 2'h3, 1'b1);
    step(1'b1, 22'h3F_FFFF, 1'b0, 2'h3, 1'b0);
    cmp(dp, exp_rd(22'h0, 2'b00, WORD));
    wr_reg(CTRL_OFS, 32'h0000_0000);
    // Byte write: read with a fault, then merge a new high byte
    din <= 16'h7E00;
    step(1'b1, 22'h8, 1'b0, 2'h1, 1'b0);
    cmp({16'h0000, oe}, 32'h0000_00FF);
    step(1'b0, 22'h8, 1'b0, 2'h1, 1'b0);
    cmp(dp & 32'h00FF_00FF, {8'h00, 2'b00, chk_of({8'h7E, WORD[7:0]}), 8'h00, WORD[7:0]});
    rd_reg(SYND_OFS, 32'h0000_0027);
    // Sticky events, masking and write-one-to-clear
    rd_reg(STATUS_OFS, 32'h0000_0007);
    cmp({31'h0, irq}, 32'h0000_0000);
    wr_reg(MASK_OFS, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    cmp({31'h0, irq}, 32'h0000_0001);
    wr_reg(STATUS_OFS, 32'h0000_0001);
    rd_reg(STATUS_OFS, 32'h0000_0006);
    cmp({31'h0, irq}, 32'h0000_0000);
    complete_run();
  end
endmodule

bind ecc_unit ecc_unit_asserts #(.DATA_W(DATA_W)) i_chk (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
  .i_read_write(i_read_write), .i_byte_output_mask_n(i_byte_output_mask_n),
  .o_data_out_write_in_bus(o_data_out_write_in_bus),
  .o_data_out_write_in_oe(o_data_out_write_in_oe),
  .o_syndrome_checkbit_out_bus(o_syndrome_checkbit_out_bus),
  .o_error(o_error), .o_correctable_error(o_correctable_error));

// >>> design/ecc_check_gen.sv
// Check-bit generator: Hamming bits plus overall parity over a data word
module ecc_check_gen
  import ecc_unit_pkg::*;
#(
  parameter int DATA_W = DEFAULT_DATA_W,
  parameter int HAM_W  = ham_bits(DEFAULT_DATA_W)
) (
  input  wire logic [DATA_W-1:0] i_data,
  output logic      [HAM_W-1:0]  o_ham,
  output logic                   o_par
);

  // Column masks: data bit i feeds Hamming bit j when its position has bit j set
  logic [HAM_W-1:0] sel [DATA_W];  // Per data bit, which check bits it drives

  genvar gi;
  genvar gj;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_pos
      assign sel[gi] = HAM_W'(data_pos(gi));
    end
    for (gj = 0; gj < HAM_W; gj++) begin : g_ham
      logic [DATA_W-1:0] hits;  // Data bits covered by this check bit
      for (gi = 0; gi < DATA_W; gi++) begin : g_cov
        assign hits[gi] = i_data[gi] & sel[gi][gj];
      end
      assign o_ham[gj] = ^hits;
    end
  endgenerate

  // Overall parity spans data and Hamming bits, giving double-error detection
  assign o_par = (^i_data) ^ (^o_ham);

endmodule

// >>> design/ecc_syndrome_decode.sv
// Syndrome decoder: one-hot flip mask and error classification
module ecc_syndrome_decode
  import ecc_unit_pkg::*;
#(
  parameter int DATA_W = DEFAULT_DATA_W,
  parameter int HAM_W  = ham_bits(DEFAULT_DATA_W)
) (
  input  wire logic [HAM_W:0]    i_syndrome,
  output logic      [DATA_W-1:0] o_flip,
  output logic                   o_error,
  output logic                   o_correctable
);

  logic [HAM_W-1:0] s_ham;     // Position of a single error
  logic             s_par;     // Overall parity mismatch: odd number of errors
  logic             chk_only;  // Position is a check bit or the parity bit itself

  assign s_ham = i_syndrome[HAM_W-1:0];
  assign s_par = i_syndrome[HAM_W];

  // One strobe per data bit, only for single errors
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_flip
      assign o_flip[gi] = s_par & (s_ham == HAM_W'(data_pos(gi)));
    end
  endgenerate

  // Power-of-two or zero positions are check bits; data stays untouched
  assign chk_only = ((s_ham & (s_ham - HAM_W'(1))) == '0);

  // Zero syndrome is a clean word; any other value flags an error
  assign o_error       = |i_syndrome;
  // Odd error count at a real position is correctable; even count is not
  assign o_correctable = s_par & (chk_only | (|o_flip));

endmodule

// >>> design/ecc_unit.sv
// ECC detect/correct unit with split RAM and system data buses, Wishbone status
// Behaviour
// - check bit count follows data word width
// - one unit spans 8 to 80 bits
// - read inputs latched only with strobe used
// - raw read data feeds output and generator
// - compare forms syndrome naming the bad bit
// - syndrome decoded one-hot flips bad bit
// - syndrome decode drives the error outputs
// - data outputs enabled per byte by mask
// - write data generates check bits out
// - check output shows syndrome on reads
// - read/write select chooses compare or generate
// - falling read/write edge latches syndrome, drives checks
// - single error corrected, double error detected
// - mismatch raises error flag, correctable flag only when correctable
// - outputs corrected only when correctable
// - correction off still flags and decodes
module ecc_unit
  import ecc_unit_pkg::*;
#(
  parameter int DATA_W = DEFAULT_DATA_W  // Multiple of eight, 8 to 80
) (
  input  wire logic                           i_clk,
  input  wire logic                           i_nrst,
  // Wishbone classic slave
  input  wire logic                           i_wb_cyc,
  input  wire logic                           i_wb_stb,
  input  wire logic                           i_wb_we,
  input  wire logic [7:0]                     i_wb_adr,
  input  wire logic [31:0]                    i_wb_dat,
  input  wire logic [3:0]                     i_wb_sel,
  output logic      [31:0]                    o_wb_dat,
  output logic                                o_wb_ack,
  output logic                                o_irq,
  // RAM side
  input  wire logic [DATA_W-1:0]              i_ram_data_in_bus,
  input  wire logic [ham_bits(DATA_W):0]      i_stored_check_in_bus,
  input  wire logic                           i_input_latch_strobe,
  // Controller side
  input  wire logic                           i_read_write,
  input  wire logic                           i_correction_enable_n,
  input  wire logic [DATA_W/BYTE_W-1:0]       i_byte_output_mask_n,
  // System data pins, two-way
  input  wire logic [DATA_W-1:0]              i_data_out_write_in_bus,
  output logic      [DATA_W-1:0]              o_data_out_write_in_bus,
  output logic      [DATA_W-1:0]              o_data_out_write_in_oe,
  // Syndrome or check bits toward RAM and controller
  output logic      [ham_bits(DATA_W):0]      o_syndrome_checkbit_out_bus,
  output logic                                o_error,
  output logic                                o_correctable_error
);

  // Check width follows the word: Hamming bits plus one overall parity
  localparam int HAM_W  = ham_bits(DATA_W);
  localparam int CHK_W  = HAM_W + 1;
  localparam int NBYTES = DATA_W / BYTE_W;

  // ---------------------------------------------------------------- Registers
  logic                   strobe_use_reg;   // Software selects latched read inputs
  logic [EVT_W-1:0]       status_reg;       // Sticky events
  logic [EVT_W-1:0]       mask_reg;         // Interrupt enables
  logic [COUNT_W-1:0]     count_reg;        // Correctable errors seen
  logic [DATA_W-1:0]      lat_data_reg;     // Strobed read data
  logic [CHK_W-1:0]       lat_chk_reg;      // Strobed stored check bits
  logic [DATA_W-1:0]      hold_data_reg;    // Last corrected read word
  logic [CHK_W-1:0]       hold_syn_reg;     // Syndrome frozen at read-to-write turn
  logic                   rw_prev_reg;      // Read/write select one cycle back
  logic                   ack_reg;          // Wishbone acknowledge
  logic [31:0]            wb_dat_reg;       // Wishbone read data
  logic                   irq_reg;          // Interrupt level
  logic [DATA_W-1:0]      dout_reg;         // Data pin value
  logic [DATA_W-1:0]      doe_reg;          // Data pin enables
  logic [CHK_W-1:0]       cbo_reg;          // Syndrome or check bits out
  logic                   err_reg;          // Error flag out
  logic                   ce_reg;           // Correctable flag out

  // ------------------------------------------------------------- Datapath nets
  logic [DATA_W-1:0]      rd_data;          // Read word in use
  logic [CHK_W-1:0]       rd_chk;           // Stored check bits in use
  logic [HAM_W-1:0]       rd_gen_ham;       // Regenerated Hamming bits
  logic                   rd_gen_par;       // Regenerated overall parity
  logic [CHK_W-1:0]       syndrome;         // Generated versus stored
  logic [DATA_W-1:0]      flip;             // One-hot bit to invert
  logic                   dec_err;          // Any mismatch
  logic                   dec_ce;           // Mismatch is correctable
  logic                   correct_en;       // Correction enabled
  logic [DATA_W-1:0]      corrected;        // Word after optional correction
  logic [DATA_W-1:0]      wr_data;          // Word whose check bits go to memory
  logic [HAM_W-1:0]       wr_ham;           // Write Hamming bits
  logic                   wr_par;           // Write overall parity
  logic                   rd_cycle;         // Read cycle in progress
  logic                   rmw_edge;         // Falling read/write edge
  logic [EVT_W-1:0]       events;           // Events this cycle
  logic                   wb_req;           // Active bus request
  logic                   wb_fire;          // Write commits at the acknowledged edge
  logic [31:0]            rd_mux;           // Register read value
  logic [EVT_W-1:0]       status_next;      // Status after set and clear

  assign rd_cycle   = i_read_write;
  assign correct_en = ~i_correction_enable_n;
  assign rmw_edge   = rw_prev_reg & ~i_read_write;

  // Read inputs pass straight through unless software asks for the strobe latch
  assign rd_data = strobe_use_reg ? lat_data_reg : i_ram_data_in_bus;
  assign rd_chk  = strobe_use_reg ? lat_chk_reg  : i_stored_check_in_bus;

  // Regenerate check bits from the raw read word, in parallel with the output path
  ecc_check_gen #(
    .DATA_W (DATA_W),
    .HAM_W  (HAM_W)
  ) u_rd_gen (
    .i_data (rd_data),
    .o_ham  (rd_gen_ham),
    .o_par  (rd_gen_par)
  );

  // Hamming part compares bits; parity part checks the whole received codeword
  assign syndrome = {rd_gen_par ^ (^rd_gen_ham) ^ (^rd_chk),
                     rd_gen_ham ^ rd_chk[HAM_W-1:0]};

  ecc_syndrome_decode #(
    .DATA_W (DATA_W),
    .HAM_W  (HAM_W)
  ) u_decode (
    .i_syndrome    (syndrome),
    .o_flip        (flip),
    .o_error       (dec_err),
    .o_correctable (dec_ce)
  );

  // Decode always runs; the enable only gates the inversion, so turning it on
  // takes effect on the next word without any warm-up
  assign corrected = rd_data ^ (correct_en ? flip : '0);

  // Write word: lanes the unit drives carry the held old word, the rest come
  // from the pins, which merges a new byte into a corrected old word
  genvar gb;
  generate
    for (gb = 0; gb < NBYTES; gb++) begin : g_lane
      assign wr_data[gb*BYTE_W +: BYTE_W] = i_byte_output_mask_n[gb]
          ? hold_data_reg[gb*BYTE_W +: BYTE_W]
          : i_data_out_write_in_bus[gb*BYTE_W +: BYTE_W];
    end
  endgenerate

  ecc_check_gen #(
    .DATA_W (DATA_W),
    .HAM_W  (HAM_W)
  ) u_wr_gen (
    .i_data (wr_data),
    .o_ham  (wr_ham),
    .o_par  (wr_par)
  );

  // ------------------------------------------------------- Input latch strobe
  // Capture on any rising clock edge with the strobe high; without it the latch sits idle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lat_data_reg <= '0;
      lat_chk_reg  <= '0;
    end else if (i_input_latch_strobe) begin
      lat_data_reg <= i_ram_data_in_bus;
      lat_chk_reg  <= i_stored_check_in_bus;
    end
  end

  // ------------------------------------------------- Read-to-write turnaround
  // Holding updates only during reads, so the word and syndrome freeze at the
  // falling select edge and stay for the write-back half
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_data_reg <= '0;
      hold_syn_reg  <= '0;
    end else if (rd_cycle) begin
      hold_data_reg <= corrected;
      hold_syn_reg  <= syndrome;
    end
  end

  // Edge detector on the select; resets to read, so a select low at reset release reads as an edge
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rw_prev_reg <= 1'h1;
    end else begin
      rw_prev_reg <= i_read_write;
    end
  end

  // ------------------------------------------------------------ Pin outputs
  // Data pins: raw or corrected word on reads, held word on the write half
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dout_reg <= '0;
    end else if (rd_cycle) begin
      dout_reg <= corrected;
    end else begin
      dout_reg <= hold_data_reg;
    end
  end

  // Byte lanes drive only while their mask is high
  genvar gk;
  generate
    for (gk = 0; gk < NBYTES; gk++) begin : g_oe
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          doe_reg[gk*BYTE_W +: BYTE_W] <= '0;
        end else begin
          doe_reg[gk*BYTE_W +: BYTE_W] <= {BYTE_W{i_byte_output_mask_n[gk]}};
        end
      end
    end
  endgenerate

  // Check pins: syndrome while reading, generated check bits while writing
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cbo_reg <= '0;
    end else if (rd_cycle) begin
      cbo_reg <= syndrome;
    end else begin
      cbo_reg <= {wr_par, wr_ham};
    end
  end

  // Error flags belong to reads only; writes show them inactive
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      err_reg <= 1'h0;
      ce_reg  <= 1'h0;
    end else begin
      err_reg <= rd_cycle & dec_err;
      ce_reg  <= rd_cycle & dec_ce;
    end
  end

  // --------------------------------------------------------------- Events
  assign events[EVT_CE_BIT]  = rd_cycle & dec_ce;
  assign events[EVT_UE_BIT]  = rd_cycle & dec_err & ~dec_ce;
  assign events[EVT_RMW_BIT] = rmw_edge;

  // ---------------------------------------------------------- Wishbone slave
  assign wb_req  = i_wb_cyc & i_wb_stb;
  // Writes land on the edge where the master sees ack, never earlier
  assign wb_fire = wb_req & i_wb_we & ack_reg & i_wb_sel[0];

  // Acknowledge one cycle after the request, drop the cycle after
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_reg <= 1'h0;
    end else begin
      ack_reg <= wb_req & ~ack_reg;
    end
  end

  // Register read mux; unmapped offsets read zero and ignore writes
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_wb_adr)
      CTRL_OFS:   rd_mux[CTRL_STROBE_BIT] = strobe_use_reg;
      STATUS_OFS: rd_mux[EVT_W-1:0]       = status_reg;
      MASK_OFS:   rd_mux[EVT_W-1:0]       = mask_reg;
      SYND_OFS: begin
        rd_mux[CHK_W-1:0]   = hold_syn_reg;
        rd_mux[SYND_ERR_BIT] = err_reg;
        rd_mux[SYND_CE_BIT]  = ce_reg;
      end
      COUNT_OFS:  rd_mux[COUNT_W-1:0]     = count_reg;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured with the request and held through the ack
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wb_dat_reg <= 32'h0000_0000;
    end else if (wb_req & ~ack_reg) begin
      wb_dat_reg <= rd_mux;
    end
  end

  // Control register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      strobe_use_reg <= CTRL_RST[CTRL_STROBE_BIT];
    end else if (wb_fire && (i_wb_adr == CTRL_OFS)) begin
      strobe_use_reg <= i_wb_dat[CTRL_STROBE_BIT];
    end
  end

  // Mask register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_reg <= MASK_RST;
    end else if (wb_fire && (i_wb_adr == MASK_OFS)) begin
      mask_reg <= i_wb_dat[EVT_W-1:0];
    end
  end

  // Status: clear first, then set, so an event in the clearing cycle survives
  always_comb begin
    status_next = status_reg;
    if (wb_fire && (i_wb_adr == STATUS_OFS)) begin
      status_next = status_next & ~i_wb_dat[EVT_W-1:0];
    end
    status_next = status_next | events;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_reg <= STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  // Correctable error counter, saturating; a write to COUNT_OFS clears it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_reg <= '0;
    end else if (wb_fire && (i_wb_adr == COUNT_OFS)) begin
      count_reg <= '0;
    end else if (events[EVT_CE_BIT] && (count_reg != '1)) begin
      count_reg <= count_reg + COUNT_W'(1);
    end
  end

  // Interrupt level from current sticky bits and enables
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_reg <= 1'h0;
    end else begin
      irq_reg <= |(status_next & mask_reg);
    end
  end

  // ---------------------------------------------------------------- Outputs
  assign o_wb_dat                    = wb_dat_reg;
  assign o_wb_ack                    = ack_reg;
  assign o_irq                       = irq_reg;
  assign o_data_out_write_in_bus     = dout_reg;
  assign o_data_out_write_in_oe      = doe_reg;
  assign o_syndrome_checkbit_out_bus = cbo_reg;
  assign o_error                     = err_reg;
  assign o_correctable_error         = ce_reg;

endmodule

// >>> design/ecc_unit_pkg.sv
// Shared constants, register map and code-construction helpers for the ECC unit
package ecc_unit_pkg;

  // Word geometry
  localparam int DEFAULT_DATA_W = 16;  // Documented single-unit width
  localparam int MAX_DATA_W     = 80;  // Widest word the code layout supports
  localparam int MAX_CHK_W      = 8;   // Check bits at the widest word
  localparam int BYTE_W         = 8;   // Lane width for output masking

  // Wishbone register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;  // Control
  localparam logic [7:0] STATUS_OFS = 8'h04;  // Sticky event flags, write one to clear
  localparam logic [7:0] MASK_OFS   = 8'h08;  // Interrupt enables, same layout as status
  localparam logic [7:0] SYND_OFS   = 8'h0C;  // Latched syndrome and live error flags
  localparam logic [7:0] COUNT_OFS  = 8'h10;  // Correctable error counter

  // Field positions
  localparam int CTRL_STROBE_BIT = 0;  // Use input latch strobe for read data
  localparam int EVT_CE_BIT      = 0;  // Correctable error seen on a read
  localparam int EVT_UE_BIT      = 1;  // Uncorrectable error seen on a read
  localparam int EVT_RMW_BIT     = 2;  // Read-modify-write turnaround seen
  localparam int EVT_W           = 3;  // Number of event bits
  localparam int SYND_ERR_BIT    = 8;  // Live error flag in syndrome register
  localparam int SYND_CE_BIT     = 9;  // Live correctable flag in syndrome register
  localparam int COUNT_W         = 16; // Width of correctable error counter

  // Values after reset
  localparam logic [31:0]      CTRL_RST   = 32'h0000_0000;
  localparam logic [EVT_W-1:0] STATUS_RST = 3'h0;
  localparam logic [EVT_W-1:0] MASK_RST   = 3'h0;

  // Hamming bits needed so that 2^r covers data plus check positions
  function automatic int ham_bits(input int w);
    int r;
    r = 1;
    while ((1 << r) < (w + r + 1)) r = r + 1;
    return r;
  endfunction

  // Codeword position of a data bit: the idx-th position that is no power of two
  function automatic int data_pos(input int idx);
    int p;
    int n;
    n = 0;
    data_pos = 0;
    for (p = 3; p < 128; p++) begin
      if ((p & (p - 1)) != 0) begin
        if ((n == idx) && (data_pos == 0)) data_pos = p;
        n = n + 1;
      end
    end
  endfunction

endpackage
